// ### dv/core_model.sv
// model of the processor core and the watchdog oscillator facing the sequencer
// assumes it shares clk and rst_b with the sequencer
`timescale 1ns/1ps
module core_model
import rst_seq_pkg::*;
#(parameter int WDO_HALF = 10)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic haltCmd,
    input wire logic sysReset_b,
    input wire logic fetchVector,
    input wire logic [15:0] vectorAddr,
    output logic haltExec,
    output logic wdoClk,
    output int fetches
);
    int div;
    // the oscillator runs free, also while sysReset_b holds the chip in reset; only rst_b stops it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div <= 0;
            wdoClk <= 1'b0;
            haltExec <= 1'b0;
            fetches <= 0;
        end
        else
        begin
            div <= (div == WDO_HALF - 1) ? 0 : div + 1;
            if (div == WDO_HALF - 1)
                wdoClk <= ~wdoClk;
            haltExec <= haltCmd & sysReset_b;
            if (fetchVector && vectorAddr === RESET_VECTOR_ADDR)
                fetches <= fetches + 1;
        end
    end
endmodule : core_model

// ### dv/debug_reset_and_stop_recovery_tb.sv
// self-checking bench for the reset sequencer
// assumes the sequencer answers APB with zero wait and registered read data
`timescale 1ns/1ps
module debug_reset_and_stop_recovery_tb;
    import rst_seq_pkg::*;
    localparam int HALF = 10;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, haltCmd, watchdogTimeout;
    logic wdoClk, haltExec, sysReset_b, debugReset_b, fetchVector, wdtIrqReq, halted;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic irqSeen;
    logic [7:0] wakePins;
    logic [15:0] vectorAddr;
    int errors = 0, tests_run = 0, cyc = 0, n, f0;
    row_t rows[6] = '{'{1, 12'h008, 32'h000000A5, 0}, '{0, 12'h008, 0, 32'h000000A5},
        '{1, 12'h00C, 32'hFFFFFFFF, 0}, '{0, 12'h00C, 0, 32'h00000000},
        '{0, 12'h004, 0, 32'h00000080}, '{0, 12'h004, 0, 32'h00000000}};
    reset_sequencer dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdoClk(wdoClk), .wakePins(wakePins), .haltExec(haltExec), .watchdogTimeout(watchdogTimeout),
        .sysReset_b(sysReset_b), .debugReset_b(debugReset_b), .fetchVector(fetchVector),
        .vectorAddr(vectorAddr), .wdtIrqReq(wdtIrqReq), .halted(halted));
    core_model #(.WDO_HALF(HALF)) core (.clk(clk), .rst_b(rst_b), .haltCmd(haltCmd),
        .sysReset_b(sysReset_b), .fetchVector(fetchVector), .vectorAddr(vectorAddr),
        .haltExec(haltExec), .wdoClk(wdoClk), .fetches(f0));
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge clk);
        r = prdata;
        chk("pslverr", 0, {31'h0, pslverr});
    endtask : apb
    // ****************
    // hold measurement
    // ****************
    task automatic hold();
        n = 0;
        while (sysReset_b !== 1'b0)
            @(posedge clk);
        while (sysReset_b === 1'b0)
        begin
            n++;
            @(posedge clk);
        end
        // the interrupt request stands for one cycle, right after the hold ends, unless watchdogTimeout is still high
        irqSeen = wdtIrqReq;
        repeat (3) @(posedge clk);
    endtask : hold
    initial
    begin
        {rst_b, psel, penable, pwrite, haltCmd, watchdogTimeout} = 0;
        paddr = 0;
        pwdata = 0;
        wakePins = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk("row", rows[i].e, r);
        end
        apb(1, CTRL_ADDR, 32'h00000002);
        hold();
        chk("dbg hold", SYS_CYCLES, n);
        chk("dbg fetch", 1, f0);
        chk("dbg keep", 1, {31'h0, debugReset_b});
        apb(0, CTRL_ADDR, 0);
        chk("rst bit", 0, {31'h0, r[CTRL_RST_BIT]});
        apb(0, STATUS_ADDR, 0);
        chk("por flag", 32'h00000080, r);
        chk("no halt", 0, {31'h0, halted});
        haltCmd <= 1;
        @(posedge clk);
        haltCmd <= 0;
        repeat (3) @(posedge clk);
        chk("halted", 1, {31'h0, halted});
        wakePins <= 8'h02;
        repeat (20) @(posedge clk);
        chk("masked pin", 1, {31'h0, halted});
        wakePins <= 8'h03;
        hold();
        chk("wdo hold", 1, (n >= 2 * HALF * (WDO_CYCLES - 1) + SYS_CYCLES
            && n <= 2 * HALF * (WDO_CYCLES + 1) + SYS_CYCLES + 4));
        chk("wake fetch", 2, f0);
        apb(0, STATUS_ADDR, 0);
        chk("stop flag", 32'h00000040, r);
        apb(0, WAKE_EN_ADDR, 0);
        chk("wake keep", 32'h000000A5, r);
        apb(1, CTRL_ADDR, 32'h0000000C);
        haltCmd <= 1;
        @(posedge clk);
        haltCmd <= 0;
        repeat (4) @(posedge clk);
        watchdogTimeout <= 1;
        @(posedge clk);
        watchdogTimeout <= 0;
        hold();
        chk("wdt hold", 1, (n >= 2 * HALF * (WDO_CYCLES - 1) + SYS_CYCLES
            && n <= 2 * HALF * (WDO_CYCLES + 1) + SYS_CYCLES + 4));
        chk("irq", 1, {31'h0, irqSeen});
        chk("vector", 32'h00000002, {16'h0, vectorAddr});
        apb(0, STATUS_ADDR, 0);
        chk("wdt flags", 32'h00000060, r);
        finish_test();
    end
endmodule : debug_reset_and_stop_recovery_tb

// ### inc/hold_count_if.sv
// carries the hold counter controls between sequencer and counter
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface hold_count_if;
    import rst_seq_pkg::*;
    logic clear;
    logic step;
    logic [CNT_W-1:0] count;
    modport ctrl (output clear, output step, input count);
    modport cnt (input clear, input step, output count);
endinterface : hold_count_if

// ### inc/rst_seq_pkg.sv
// package for the debug reset and halt recovery sequencer
// assumes a 250 MHz system clock and a slow watchdog oscillator clock sampled as a pin
package rst_seq_pkg;
    localparam int WDO_CYCLES = 66;
    localparam int SYS_CYCLES = 16;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] WDO_LAST = CNT_W'(WDO_CYCLES - 1);
    localparam logic [CNT_W-1:0] SYS_LAST = CNT_W'(SYS_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
    // status flag positions inside the watchdog control/status byte
    localparam int POR_BIT = 7;
    localparam int STOP_BIT = 6;
    localparam int WDT_BIT = 5;
    localparam int EXT_BIT = 4;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [3:0] ROLE_HIGH_CLEAR = 4'h0;
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] CTRL_ADDR = 12'h000;
    localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h004;
    localparam logic [APB_AW-1:0] WAKE_EN_ADDR = 12'h008;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_WDT_IRQ_BIT = 2;
    localparam int CTRL_IRQ_EN_BIT = 3;
    localparam int WAKE_W = 8;
    typedef enum logic [2:0] {
        RUN = 3'b000,
        HALTED = 3'b001,
        HOLD_WDO = 3'b011,
        HOLD_SYS = 3'b010,
        DBG_RESET = 3'b110
    } seq_state_t;
endpackage : rst_seq_pkg

// ### logic/hold_counter.sv
// hold counter for both recovery phases
// assumes clear and step come from logic on the system clock
`timescale 1ns/1ps
module hold_counter
(
    input wire logic clk,
    input wire logic rst_b,
    hold_count_if.cnt hc
);
    import rst_seq_pkg::*;
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } cnt_state_t;
    cnt_state_t s_q;
    cnt_state_t s_d;
    always_comb
    begin
        s_d = s_q;
        if (hc.clear)
        begin
            s_d.cnt = CNT_ZERO;
        end
        else if (hc.step)
        begin
            s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign hc.count = s_q.cnt;
endmodule : hold_counter

// ### logic/reset_sequencer.sv
// debug reset and halt-state recovery sequencer with an APB register port
// assumes the watchdog oscillator and wake pins are asynchronous; core signals share clk
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module reset_sequencer
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rst_seq_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdoClk,
    input wire logic [rst_seq_pkg::WAKE_W-1:0] wakePins,
    input wire logic haltExec,
    input wire logic watchdogTimeout,
    output logic sysReset_b,
    output logic debugReset_b,
    output logic fetchVector,
    output logic [15:0] vectorAddr,
    output logic wdtIrqReq,
    output logic halted
);
    import rst_seq_pkg::*;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        seq_state_t st;
        logic [1:0] wdoSync;
        logic wdoPrev;
        logic [WAKE_W-1:0] wakeS1;
        logic [WAKE_W-1:0] wakeS2;
        logic [WAKE_W-1:0] wakePrev;
        logic [WAKE_W-1:0] wakeEn;
        logic rstReq;
        logic wdtIrqMode;
        logic irqEn;
        logic [7:0] status;
        logic dbgCause;
        logic wdtWake;
        logic fetch;
        logic irqReq;
        logic [31:0] rdata;
    } seq_t;
    seq_t s_q;
    seq_t s_d;
    hold_count_if hc ();
    hold_counter u_cnt (.clk(clk), .rst_b(rst_b), .hc(hc));
    logic wdoRise;
    logic [WAKE_W-1:0] wakeEdge;
    logic wake;
    logic apbWr;
    logic apbRd;
    assign wdoRise = s_q.wdoSync[1] & ~s_q.wdoPrev;
    assign wakeEdge = (s_q.wakeS2 ^ s_q.wakePrev) & s_q.wakeEn;
    assign wake = (|wakeEdge) | watchdogTimeout;
    assign apbWr = psel & penable & pwrite;
    assign apbRd = psel & penable & ~pwrite;
    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        hc.clear = 1'b0;
        hc.step = 1'b0;
        s_d.wdoSync = {s_q.wdoSync[0], wdoClk};
        s_d.wdoPrev = s_q.wdoSync[1];
        s_d.wakeS1 = wakePins;
        s_d.wakeS2 = s_q.wakeS1;
        s_d.wakePrev = s_q.wakeS2;
        s_d.fetch = 1'b0;
        if (apbWr && paddr == CTRL_ADDR)
        begin
            s_d.rstReq = pwdata[CTRL_RST_BIT];
            s_d.wdtIrqMode = pwdata[CTRL_WDT_IRQ_BIT];
            s_d.irqEn = pwdata[CTRL_IRQ_EN_BIT];
        end
        if (apbWr && paddr == WAKE_EN_ADDR)
        begin
            s_d.wakeEn = pwdata[WAKE_W-1:0];
        end
        if (apbRd)
        begin
            unique case (paddr)
                CTRL_ADDR: s_d.rdata = 32'({s_q.irqEn, s_q.wdtIrqMode, s_q.rstReq, 1'b0});
                STATUS_ADDR:
                begin
                    s_d.rdata = 32'(s_q.status);
                    s_d.status[7:4] = ROLE_HIGH_CLEAR;
                end
                WAKE_EN_ADDR: s_d.rdata = 32'(s_q.wakeEn);
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        unique case (s_q.st)
            RUN:
            begin
                if (s_q.rstReq)
                begin
                    s_d.st = HOLD_SYS;
                    s_d.dbgCause = 1'b1;
                    hc.clear = 1'b1;
                end
                else if (haltExec)
                begin
                    s_d.st = HALTED;
                end
            end
            HALTED:
            begin
                if (wake)
                begin
                    s_d.st = HOLD_WDO;
                    hc.clear = 1'b1;
                    s_d.wdtWake = watchdogTimeout;
                end
            end
            HOLD_WDO:
            begin
                if (wdoRise)
                begin
                    if (hc.count == WDO_LAST)
                    begin
                        s_d.st = HOLD_SYS;
                        hc.clear = 1'b1;
                    end
                    else
                    begin
                        hc.step = 1'b1;
                    end
                end
            end
            HOLD_SYS:
            begin
                s_d.rstReq = 1'b0;
                if (hc.count == SYS_LAST)
                begin
                    s_d.st = RUN;
                    s_d.fetch = 1'b1;
                    if (s_q.dbgCause)
                    begin
                        s_d.status = STATUS_RESET;
                    end
                    else
                    begin
                        s_d.status[STOP_BIT] = 1'b1;
                        s_d.status[WDT_BIT] = s_q.wdtWake;
                        s_d.irqReq = s_q.wdtWake & s_q.wdtIrqMode & s_q.irqEn;
                    end
                    s_d.dbgCause = 1'b0;
                    s_d.wdtWake = 1'b0;
                end
                else
                begin
                    hc.step = 1'b1;
                end
            end
            default:
            begin
                s_d.st = RUN;
            end
        endcase
        if (s_q.irqReq && s_q.st == RUN && !watchdogTimeout)
        begin
            s_d.irqReq = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
            s_q.status <= STATUS_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    // the debugger reset never drives debugReset_b; only the pin reset does
    assign debugReset_b = rst_b;
    // only the status byte changes; the rest of the chip keeps its contents (halt recovery)
    assign sysReset_b = !(s_q.st == HOLD_WDO || s_q.st == HOLD_SYS);
    assign fetchVector = s_q.fetch;
    assign vectorAddr = RESET_VECTOR_ADDR;
    assign wdtIrqReq = s_q.irqReq;
    assign halted = (s_q.st == HALTED);
    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // ****************************************
    // checks
    // ****************************************
    sequence hold_done_s;
        s_q.st == HOLD_SYS && hc.count == SYS_LAST;
    endsequence
    a_halt_entry: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.st == RUN && $past(s_q.st) == RUN && !$past(s_q.rstReq) && s_d.st == HALTED) |-> haltExec)
        else $error("halt entered without halt instruction");
    a_sys_phase: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(s_q.st == HOLD_SYS) && $past(s_q.st) == HOLD_WDO)
        |-> (!sysReset_b)[*8] ##1 (!sysReset_b)[*8] ##1 fetchVector)
        else $error("system clock phase is not 16 cycles");
    a_req_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.st == HOLD_SYS) |=> !s_q.rstReq)
        else $error("reset request not cleared");
    a_por_flag: assert property (@(posedge clk) disable iff (!rst_b)
        (hold_done_s and s_q.dbgCause) |=> s_q.status[POR_BIT])
        else $error("power-on flag not set");
    a_stop_flag: assert property (@(posedge clk) disable iff (!rst_b)
        (hold_done_s and !s_q.dbgCause) |=> s_q.status[STOP_BIT] && fetchVector)
        else $error("recovery flag not set");
    a_wdt_flag: assert property (@(posedge clk) disable iff (!rst_b)
        (hold_done_s and s_q.wdtWake) |=> s_q.status[WDT_BIT])
        else $error("timeout flag not set");
    a_wake_start: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.st == HALTED && wake) |=> s_q.st == HOLD_WDO && hc.count == CNT_ZERO)
        else $error("wake did not start recovery");
    a_vector_fetch: assert property (@(posedge clk) disable iff (!rst_b)
        fetchVector |-> vectorAddr == RESET_VECTOR_ADDR && sysReset_b && $past(!sysReset_b))
        else $error("vector fetch outside recovery end");
    a_dbg_start: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.st == RUN && s_q.rstReq) |=> s_q.st == HOLD_SYS && !sysReset_b && debugReset_b)
        else $error("debug reset did not start");
endmodule : reset_sequencer
